// *** pkg/pbs_if.sv ***
// Pin bundle between the SRAM and its controller
interface pbs_if;
  logic clock_qualify_n;                          // Edge ignored when high
  logic chip_select_1_n;
  logic chip_select_2;
  logic chip_select_3_n;
  logic burst_step_or_load;                       // High steps, low loads
  logic write_n;                                  // Low selects write
  logic [pbs_pkg::LANES-1:0] byte_lane_select_n;
  logic [pbs_pkg::ADDR_W-1:0] addr;
  logic output_drive_n;                           // Output enable, low on
  logic sleep_request;
  logic [pbs_pkg::DATA_W-1:0] data_dev_o;
  logic data_dev_oe;
  logic [pbs_pkg::PAR_W-1:0] parity_dev_o;
  logic parity_dev_oe;
  logic [pbs_pkg::DATA_W-1:0] data_host_o;
  logic data_host_oe;
  logic [pbs_pkg::PAR_W-1:0] parity_host_o;
  logic parity_host_oe;
  logic [pbs_pkg::DATA_W-1:0] data_lines;
  logic [pbs_pkg::PAR_W-1:0] parity_lines;

  // Resolved shared lines; an undriven bus reads as zero
  assign data_lines = data_dev_oe ? data_dev_o :
                      (data_host_oe ? data_host_o : '0);
  assign parity_lines = parity_dev_oe ? parity_dev_o :
                        (parity_host_oe ? parity_host_o : '0);

  modport dev (
    input clock_qualify_n, chip_select_1_n, chip_select_2,
    input chip_select_3_n, burst_step_or_load, write_n,
    input byte_lane_select_n, addr, output_drive_n, sleep_request,
    input data_lines, parity_lines,
    output data_dev_o, data_dev_oe, parity_dev_o, parity_dev_oe
  );

  modport host (
    output clock_qualify_n, chip_select_1_n, chip_select_2,
    output chip_select_3_n, burst_step_or_load, write_n,
    output byte_lane_select_n, addr, output_drive_n, sleep_request,
    input data_lines, parity_lines,
    output data_host_o, data_host_oe, parity_host_o, parity_host_oe
  );
endinterface

// *** pkg/pbs_pkg.sv ***
// Shared constants for the pipelined burst SRAM and its controller
package pbs_pkg;

  // ***************************************************************
  // Word and array geometry
  // ***************************************************************
  localparam int ADDR_W = 20;          // One million words
  localparam int DATA_W = 32;          // Data lines
  localparam int PAR_W = 4;            // Parity lines, one per lane
  localparam int WORD_W = DATA_W + PAR_W;
  localparam int LANES = 4;            // Byte lanes per word
  localparam int LANE_W = 8;           // Data bits per lane
  localparam int DEPTH = 1048576;      // Words in the array
  localparam int CHK_W = 6;            // Hidden check bits per word
  localparam int BURST_W = 2;          // Counter width, four beats

  // ***************************************************************
  // Burst order strap values
  // ***************************************************************
  localparam logic ORDER_LINEAR = 1'b0;
  localparam logic ORDER_INTERLEAVED = 1'b1;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_PERIOD_NS = 100;  // 10 MHz
  localparam int SYNC_STAGES = 2;      // Sleep pin synchroniser depth
  localparam int SLEEP_REC_NS = 200;   // Sleep recovery, two cycles
  localparam int SLEEP_REC_CYC =
    (SLEEP_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_CNT_W = 2;

  // ***************************************************************
  // Read return buffer
  // ***************************************************************
  localparam int BUF_DEPTH = 2;
  localparam int BUF_W = WORD_W;
  localparam int BUF_PTR_W = 1;
  localparam int BUF_CNT_W = 2;

endpackage

// *** rtl/pbs_device.sv ***
// Pipelined burst SRAM core with burst counter, sleep and ECC
module pbs_device (
  input wire logic clock,                // 10 MHz clock
  input wire logic rst_n,                // Synchronous reset, low active
  input wire logic burst_order,          // Order strap, high interleaved
  output logic asleep,                   // Sleep state reached
  output logic ecc_fixed,                // Pulse: read word was corrected
  pbs_if.dev link                        // Pins toward the controller
);

  // ***************************************************************
  // Check-bit helpers
  // ***************************************************************

  // Hamming check value: XOR of code positions of the set data bits
  function automatic logic [pbs_pkg::CHK_W-1:0] ecc_gen(
    input logic [pbs_pkg::WORD_W-1:0] d
  );
    logic [pbs_pkg::CHK_W-1:0] c;
    logic [pbs_pkg::CHK_W-1:0] p;
    c = '0;
    p = 6'h2;
    for (int i = 0; i < pbs_pkg::WORD_W; i++) begin
      p = p + 6'h1;
      if ((p & (p - 6'h1)) == 6'h0) begin
        p = p + 6'h1;
      end
      if (d[i]) begin
        c = c ^ p;
      end
    end
    return c;
  endfunction

  // Flip the one data bit whose position equals the syndrome
  function automatic logic [pbs_pkg::WORD_W-1:0] ecc_fix(
    input logic [pbs_pkg::WORD_W-1:0] d,
    input logic [pbs_pkg::CHK_W-1:0] syn
  );
    logic [pbs_pkg::WORD_W-1:0] r;
    logic [pbs_pkg::CHK_W-1:0] p;
    r = d;
    p = 6'h2;
    for (int i = 0; i < pbs_pkg::WORD_W; i++) begin
      p = p + 6'h1;
      if ((p & (p - 6'h1)) == 6'h0) begin
        p = p + 6'h1;
      end
      if (p == syn) begin
        r[i] = ~r[i];
      end
    end
    return r;
  endfunction

  // ***************************************************************
  // Pin capture
  // ***************************************************************
  logic [pbs_pkg::SYNC_STAGES-1:0] sleep_sync_r;
  logic [pbs_pkg::SYNC_STAGES-1:0] order_sync_r;
  logic order_r;
  logic en;
  logic sel;
  logic load;

  // Sleep pin is asynchronous, so two flops before use; this
  // synchroniser is also what makes entry and exit take two cycles
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sleep_sync_r <= '0;
    end else begin
      sleep_sync_r <= {sleep_sync_r[0], link.sleep_request};
    end
  end

  // Strap passes a synchroniser, is followed while reset is held and is frozen once reset is released
  always_ff @(posedge clock) begin
    order_sync_r <= {order_sync_r[0], burst_order};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      order_r <= order_sync_r[1];
    end
  end

  assign asleep = sleep_sync_r[1];
  assign en = !link.clock_qualify_n && !asleep;
  assign sel = !link.chip_select_1_n && link.chip_select_2 &&
               !link.chip_select_3_n;
  assign load = !link.burst_step_or_load;

  // ***************************************************************
  // Burst counter
  // ***************************************************************
  logic bst_act_r;
  logic bst_wr_r;
  logic [pbs_pkg::ADDR_W-1:0] bst_base_r;
  logic [pbs_pkg::BURST_W-1:0] bst_step_r;
  logic [pbs_pkg::BURST_W-1:0] step_nxt;
  logic [pbs_pkg::BURST_W-1:0] burst_lo;
  logic acc_go;
  logic acc_wr;
  logic [pbs_pkg::ADDR_W-1:0] acc_addr;

  // Only the two low bits move; the upper bits stay at the base
  assign step_nxt = bst_step_r + 2'h1;
  assign burst_lo = (order_r == pbs_pkg::ORDER_INTERLEAVED) ?
                    (bst_base_r[1:0] ^ step_nxt) :
                    (bst_base_r[1:0] + step_nxt);

  // Access presented at this edge: a load or a step of a live burst
  assign acc_go = load ? sel : bst_act_r;
  assign acc_wr = load ? !link.write_n : bst_wr_r;
  assign acc_addr = load ? link.addr :
                    {bst_base_r[pbs_pkg::ADDR_W-1:2], burst_lo};

  // A step advances even through chip selects and write strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bst_act_r <= 1'b0;
      bst_wr_r <= 1'b0;
      bst_base_r <= '0;
      bst_step_r <= '0;
    end else if (asleep) begin
      bst_act_r <= 1'b0;
    end else if (en) begin
      if (load) begin
        bst_act_r <= sel;
        bst_wr_r <= !link.write_n;
        bst_base_r <= link.addr;
        bst_step_r <= '0;
      end else begin
        bst_step_r <= step_nxt;
      end
    end
  end

  // ***************************************************************
  // Access pipeline
  // ***************************************************************
  logic s1_vld_r;
  logic s1_wr_r;
  logic [pbs_pkg::ADDR_W-1:0] s1_addr_r;
  logic [pbs_pkg::LANES-1:0] s1_be_n_r;
  logic s2_vld_r;
  logic [pbs_pkg::ADDR_W-1:0] s2_addr_r;
  logic [pbs_pkg::LANES-1:0] s2_be_n_r;

  // A new command is taken at every qualified edge, no wait states
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_vld_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_addr_r <= '0;
      s1_be_n_r <= '1;
    end else if (asleep) begin
      s1_vld_r <= 1'b0;
    end else if (en) begin
      s1_vld_r <= acc_go;
      s1_wr_r <= acc_wr;
      s1_addr_r <= acc_addr;
      s1_be_n_r <= link.byte_lane_select_n;
    end
  end

  // Write stage: the data beat is taken one edge after this stage loads
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s2_vld_r <= 1'b0;
      s2_addr_r <= '0;
      s2_be_n_r <= '1;
    end else if (asleep) begin
      s2_vld_r <= 1'b0;
    end else if (en) begin
      s2_vld_r <= s1_vld_r && s1_wr_r;
      s2_addr_r <= s1_addr_r;
      s2_be_n_r <= s1_be_n_r;
    end
  end

  // ***************************************************************
  // Array with hidden check bits
  // ***************************************************************
  logic [pbs_pkg::WORD_W-1:0] mem [pbs_pkg::DEPTH];
  logic [pbs_pkg::CHK_W-1:0] chk_mem [pbs_pkg::DEPTH];
  logic [pbs_pkg::WORD_W-1:0] din;
  logic [pbs_pkg::WORD_W-1:0] old_word;
  logic [pbs_pkg::WORD_W-1:0] wr_word;
  logic [pbs_pkg::WORD_W-1:0] rd_raw;
  logic [pbs_pkg::CHK_W-1:0] rd_syn;
  logic [pbs_pkg::WORD_W-1:0] rd_word;
  logic fwd;

  assign din = {link.parity_lines, link.data_lines};

  // Byte writes are read-modify-write so check bits stay whole
  always_comb begin
    old_word = ecc_fix(mem[s2_addr_r],
                       chk_mem[s2_addr_r] ^ ecc_gen(mem[s2_addr_r]));
    wr_word = old_word;
    for (int k = 0; k < pbs_pkg::LANES; k++) begin
      if (!s2_be_n_r[k]) begin
        wr_word[k*pbs_pkg::LANE_W +: pbs_pkg::LANE_W] =
          din[k*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
        wr_word[pbs_pkg::DATA_W + k] = din[pbs_pkg::DATA_W + k];
      end
    end
  end

  // Write completes at the second qualified edge after the command
  always_ff @(posedge clock) begin
    if (en && s2_vld_r) begin
      mem[s2_addr_r] <= wr_word;
      chk_mem[s2_addr_r] <= ecc_gen(wr_word);
    end
  end

  // Multi-bit errors can give a syndrome that matches another data bit, which is then flipped
  assign rd_raw = mem[s1_addr_r];
  assign rd_syn = chk_mem[s1_addr_r] ^ ecc_gen(rd_raw);
  assign rd_word = ecc_fix(rd_raw, rd_syn);
  // A read right behind a write to the same word sees the new word
  assign fwd = s2_vld_r && (s2_addr_r == s1_addr_r);

  // ***************************************************************
  // Output register and drivers
  // ***************************************************************
  logic out_vld_r;
  logic [pbs_pkg::WORD_W-1:0] out_q_r;
  logic drive;

  // Writes and deselects clear the drive one edge after they load
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_vld_r <= 1'b0;
      out_q_r <= '0;
    end else if (asleep) begin
      out_vld_r <= 1'b0;
    end else if (en) begin
      out_vld_r <= s1_vld_r && !s1_wr_r;
      out_q_r <= fwd ? wr_word : rd_word;
    end
  end

  // Flags a correction on the beat that loads the output register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ecc_fixed <= 1'b0;
    end else begin
      ecc_fixed <= en && s1_vld_r && !s1_wr_r && !fwd &&
                   (rd_syn != '0);
    end
  end

  // Output enable is used as is; it gates but never stores
  assign drive = out_vld_r && !link.output_drive_n && !asleep;
  assign link.data_dev_oe = drive;
  assign link.parity_dev_oe = drive;
  assign link.data_dev_o = out_q_r[pbs_pkg::DATA_W-1:0];
  assign link.parity_dev_o = out_q_r[pbs_pkg::WORD_W-1:pbs_pkg::DATA_W];

endmodule

// *** rtl/pbs_host.sv ***
// Controller end: issues commands, drives write data, buffers reads
module pbs_host (
  input wire logic clock,                          // 10 MHz clock
  input wire logic rst_n,                          // Sync reset, low active
  input wire logic req_valid,                      // Request offered
  output logic req_ready,                          // Request taken
  input wire logic req_write,                      // High write, low read
  input wire logic req_cont,                       // Step burst, no address
  input wire logic [pbs_pkg::ADDR_W-1:0] req_addr, // Word address
  input wire logic [pbs_pkg::WORD_W-1:0] req_data, // Parity over data
  input wire logic [pbs_pkg::LANES-1:0] req_be_n,  // Lane selects, low on
  output logic rsp_valid,                          // Read word available
  input wire logic rsp_ready,                      // Read word accepted
  output logic [pbs_pkg::WORD_W-1:0] rsp_data,     // Read word
  input wire logic sleep_in,                       // Ask device to sleep
  output logic sleeping,                           // Device put to sleep
  pbs_if.host link                                 // Pins toward the SRAM
);

  typedef enum logic [3:0] {
    PBS_RUN = 4'b0001,
    PBS_DRAIN = 4'b0010,
    PBS_SLEEP = 4'b0100,
    PBS_RECOVER = 4'b1000
  } pbs_hstate_t;

  // ***************************************************************
  // Read return buffer
  // ***************************************************************
  logic [pbs_pkg::BUF_W-1:0] buf_mem [pbs_pkg::BUF_DEPTH];
  logic [pbs_pkg::BUF_PTR_W-1:0] wr_ptr_r;
  logic [pbs_pkg::BUF_PTR_W-1:0] rd_ptr_r;
  logic [pbs_pkg::BUF_CNT_W-1:0] cnt_r;
  logic full;
  logic en;
  logic push;
  logic pop;

  // A full buffer stalls the link, so landing words wait on the pins
  assign full = (cnt_r == 2'(pbs_pkg::BUF_DEPTH));
  assign en = !full;
  assign pop = rsp_valid && rsp_ready;
  assign rsp_valid = (cnt_r != '0);
  assign rsp_data = buf_mem[rd_ptr_r];

  // ***************************************************************
  // Command pins and in-flight tracking
  // ***************************************************************
  pbs_hstate_t state_r;
  logic [pbs_pkg::REC_CNT_W-1:0] rec_cnt_r;
  logic cs_r;
  logic adv_r;
  logic we_n_r;
  logic [pbs_pkg::ADDR_W-1:0] addr_r;
  logic [pbs_pkg::LANES-1:0] be_n_r;
  logic [2:0] vld_r;
  logic [2:0] wr_r;
  logic [pbs_pkg::WORD_W-1:0] dat_r [3];
  logic issue;
  logic idle;

  assign req_ready = (state_r == PBS_RUN) && en && !sleep_in;
  assign issue = req_valid && req_ready;
  assign idle = (vld_r == 3'h0);
  assign push = en && vld_r[2] && !wr_r[2];

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr_r] <= {link.parity_lines, link.data_lines};
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + 2'(push) - 2'(pop);
    end
  end

  // Idle beats deselect with a load so no stale burst continues
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cs_r <= 1'b0;
      adv_r <= 1'b0;
      we_n_r <= 1'b1;
      addr_r <= '0;
      be_n_r <= '1;
    end else if (en) begin
      cs_r <= issue;
      adv_r <= issue && req_cont;
      we_n_r <= !(issue && req_write);
      addr_r <= req_addr;
      be_n_r <= issue ? req_be_n : '1;
    end
  end

  // Pins, device load, device output stage: write data on the last
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vld_r <= '0;
      wr_r <= '0;
    end else if (en) begin
      vld_r <= {vld_r[1:0], issue};
      wr_r <= {wr_r[1:0], req_write};
      dat_r[0] <= req_data;
      dat_r[1] <= dat_r[0];
      dat_r[2] <= dat_r[1];
    end
  end

  assign link.clock_qualify_n = full;
  assign link.chip_select_1_n = !cs_r;
  assign link.chip_select_2 = cs_r;
  assign link.chip_select_3_n = !cs_r;
  assign link.burst_step_or_load = adv_r;
  assign link.write_n = we_n_r;
  assign link.addr = addr_r;
  assign link.byte_lane_select_n = be_n_r;
  // Release the device drivers in the same cycle that we drive our own data
  assign link.output_drive_n = vld_r[2] && wr_r[2];
  assign link.data_host_oe = vld_r[2] && wr_r[2];
  assign link.parity_host_oe = vld_r[2] && wr_r[2];
  assign link.data_host_o = dat_r[2][pbs_pkg::DATA_W-1:0];
  assign link.parity_host_o = dat_r[2][pbs_pkg::WORD_W-1:pbs_pkg::DATA_W];

  // ***************************************************************
  // Sleep sequencing
  // ***************************************************************

  // Drain in-flight work first; keep deselected through recovery
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= PBS_RUN;
      rec_cnt_r <= '0;
    end else begin
      case (state_r)
        PBS_RUN: begin
          if (sleep_in) begin
            state_r <= PBS_DRAIN;
          end
        end
        PBS_DRAIN: begin
          if (idle) begin
            state_r <= PBS_SLEEP;
          end
        end
        PBS_SLEEP: begin
          if (!sleep_in) begin
            state_r <= PBS_RECOVER;
            rec_cnt_r <= pbs_pkg::REC_CNT_W'(pbs_pkg::SLEEP_REC_CYC);
          end
        end
        PBS_RECOVER: begin
          rec_cnt_r <= rec_cnt_r - 1'b1;
          if (rec_cnt_r == 2'h1) begin
            state_r <= PBS_RUN;
          end
        end
        default: begin
          state_r <= PBS_RUN;
        end
      endcase
    end
  end

  assign link.sleep_request = (state_r == PBS_SLEEP);
  assign sleeping = (state_r == PBS_SLEEP);

endmodule

// *** testbench/pbs_props.sv ***
// Link protocol assertions for the burst SRAM and its controller
module pbs_props (
  input wire logic clock, // Link clock
  input wire logic rst_n, // Sync reset, low active
  input wire logic clock_qualify_n, // Edge skipped when high
  input wire logic chip_select_1_n, // Select, low on
  input wire logic chip_select_2, // Select, high on
  input wire logic chip_select_3_n, // Select, low on
  input wire logic burst_step_or_load, // High steps, low loads
  input wire logic write_n, // Low writes
  input wire logic output_drive_n, // Output enable, low on
  input wire logic sleep_request, // Sleep pin
  input wire logic [pbs_pkg::DATA_W-1:0] data_dev_o, // Device data
  input wire logic data_dev_oe, // Device drives
  input wire logic data_host_oe // Host drives
);
  // ********
  // Decoded commands
  // ********
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Sleep pin is folded in because the device clears its pipe on entry
  wire q = !clock_qualify_n && !sleep_request;
  wire sel = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  wire ld = q && !burst_step_or_load;
  // A load whose very next edge is also qualified
  sequence rd_s;
    (ld && sel && write_n) ##1 q;
  endsequence
  sequence wr_s;
    (ld && sel && !write_n) ##1 q;
  endsequence
  sequence ds_s;
    (ld && !sel) ##1 q;
  endsequence
  // ********
  // Checks
  // ********
  a_read_drive: assert property (
    rd_s |=> data_dev_oe == !output_drive_n)
    else $error("read word not driven as enabled");
  a_write_release: assert property (
    wr_s |=> !data_dev_oe)
    else $error("device drives after write");
  a_deselect_off: assert property (
    ds_s |=> !data_dev_oe)
    else $error("device drives after deselect");
  a_write_data: assert property (
    wr_s |=> data_host_oe)
    else $error("write data missing at capture edge");
  a_no_contention: assert property (
    !(data_dev_oe && data_host_oe))
    else $error("both ends drive the data lines");
  a_stall_hold: assert property (
    clock_qualify_n && !sleep_request |=> $stable(data_dev_o))
    else $error("output register moved on skipped edge");
  a_sleep_deselect: assert property (
    sleep_request |-> !sel)
    else $error("selected while sleep asked");
  a_wake_deselect: assert property (
    $fell(sleep_request) |-> (!sel)[*2])
    else $error("selected during sleep recovery");
  a_load_after_desel: assert property (
    ld && !sel |=> !burst_step_or_load)
    else $error("burst step after deselect");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> !data_dev_oe)
    else $error("device drives after reset");
endmodule

// *** testbench/test_pipelined_burst_sram.sv ***
// Self-checking bench joining the SRAM to its controller
module test_pipelined_burst_sram;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
  logic clock, rst_n, burst_order, req_valid, req_write, req_cont;
  logic rsp_ready, sleep_in, hold, ecc_seen;
  logic req_ready, rsp_valid, sleeping, asleep, ecc_fixed;
  logic [pbs_pkg::ADDR_W-1:0] req_addr, base, bb;
  logic [pbs_pkg::WORD_W-1:0] req_data, rsp_data, got;
  logic [pbs_pkg::LANES-1:0] req_be_n;
  logic [pbs_pkg::WORD_W-1:0] mem [logic [pbs_pkg::ADDR_W-1:0]];
  logic [pbs_pkg::WORD_W-1:0] exp_q [$];
  logic [31:0] seed, r;
  logic [1:0] beat;
  logic [5:0] i;
  int n_errors, checked;
  pbs_if link ();
  pbs_device u_pbs_device (.clock(clock), .rst_n(rst_n),
    .burst_order(burst_order), .asleep(asleep), .ecc_fixed(ecc_fixed),
    .link(link.dev));
  pbs_host u_pbs_host (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_cont(req_cont), .req_addr(req_addr), .req_data(req_data),
    .req_be_n(req_be_n), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .sleep_in(sleep_in), .sleeping(sleeping),
    .link(link.host));
  pbs_props u_pbs_props (.clock(clock), .rst_n(rst_n),
    .clock_qualify_n(link.clock_qualify_n),
    .chip_select_1_n(link.chip_select_1_n),
    .chip_select_2(link.chip_select_2),
    .chip_select_3_n(link.chip_select_3_n),
    .burst_step_or_load(link.burst_step_or_load),
    .write_n(link.write_n), .output_drive_n(link.output_drive_n),
    .sleep_request(link.sleep_request), .data_dev_o(link.data_dev_o),
    .data_dev_oe(link.data_dev_oe), .data_host_oe(link.data_host_oe));
  // ********
  // Clock, randomness and read-side checking
  // ********
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Random back-pressure keeps the two-entry buffer busy
  always @(posedge clock) begin
    rsp_ready <= !hold && (xs() & 32'h0000_0003) != 32'h0000_0000;
    if (ecc_fixed === 1'b1) ecc_seen <= 1'b1;
  end
  // Sampled mid-cycle so pop and compare see settled values
  always @(negedge clock) begin
    if (rst_n && rsp_valid && rsp_ready) begin
      got = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
      `CHK(rsp_data, got)
    end
  end
  // ********
  // Drivers
  // ********
  // Models the word at issue time, so reads expect program order
  task automatic op(input logic w, c, input logic [19:0] a,
                    input logic [3:0] be);
    logic [31:0] v;
    logic [19:0] ea;
    logic [35:0] d;
    v = xs();
    d = {v[3:0], xs()};
    beat = c ? beat + 2'd1 : 2'd0;
    if (!c) bb = a;
    ea = {bb[19:2], burst_order ? bb[1:0] ^ beat : bb[1:0] + beat};
    if (w) begin
      for (int k = 0; k < 4; k++) begin
        if (!be[k]) mem[ea][8*k +: 8] = d[8*k +: 8];
        if (!be[k]) mem[ea][32+k] = d[32+k];
      end
    end
    else exp_q.push_back(mem[ea]);
    req_valid <= 1'b1;
    req_write <= w;
    req_cont <= c;
    req_addr <= a;
    req_data <= d;
    req_be_n <= be;
    @(negedge clock);
    while (req_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
  endtask
  task automatic drain();
    req_valid <= 1'b0;
    while (exp_q.size() != 0) @(posedge clock);
  endtask
  // Strap is frozen at reset, so each order gets a fresh reset
  task automatic reset_to(input logic o);
    burst_order <= o;
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
  endtask
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    seed = 32'he1e1;
    {rst_n, burst_order, req_valid, req_write, req_cont} = 5'h0;
    {rsp_ready, sleep_in, hold, ecc_seen} = 4'h0;
    {req_addr, req_data, req_be_n} = '0;
    for (int o = 0; o < 2; o++) begin
      reset_to(o[0]);
      r = xs();
      base = {r[19:3], 3'b000};
      for (i = 0; i < 8; i++) op(1'b1, 1'b0, base + i, 4'h0);
      for (i = 0; i < 4; i++) begin
        op(1'b0, i != 0, base + r[21:20], 4'h0);
      end
      for (i = 0; i < 4; i++) begin
        op(1'b1, i != 0, base + r[23:22], 4'(xs()) & 4'he);
      end
      for (i = 0; i < 8; i++) begin
        op(1'b0, i[1:0] != 0, base + i, 4'h0);
      end
      for (i = 0; i < 32; i++) begin
        r = xs();
        op(r[0], 1'b0, base + r[3:1], r[7:4] & 4'he);
      end
      drain();
      $display("burst order %0d test done", o);
    end
    // Three reads against a held buffer force a device stall
    hold <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 3; i++) op(1'b0, 1'b0, base + i, 4'h0);
    req_valid <= 1'b0;
    repeat (8) @(posedge clock);
    @(negedge clock);
    `CHK({req_ready, link.clock_qualify_n}, 2'b01)
    @(posedge clock);
    hold <= 1'b0;
    drain();
    $display("buffer full test done");
    sleep_in <= 1'b1;
    repeat (12) @(posedge clock);
    @(negedge clock);
    `CHK({sleeping, asleep, req_ready, link.data_dev_oe}, 4'hc)
    @(posedge clock);
    sleep_in <= 1'b0;
    for (i = 0; i < 8; i++) op(1'b0, 1'b0, base + i, 4'h0);
    drain();
    $display("sleep test done");
    `CHK(ecc_seen, 1'b0)
    summarize();
  end
  // Cuts a hang well past the expected few hundred cycles
  initial begin
    repeat (8000) @(posedge clock);
    n_errors++;
    $display("watchdog expired at %0t", $time);
    summarize();
  end
endmodule
